/* core/fdc_pos_map.svh */
// Register map, fields and timing of the head positioning block
`ifndef FDC_POS_MAP_SVH
`define FDC_POS_MAP_SVH
`define A_CMD 8'h00
`define A_TGT 8'h04
`define A_CFG 8'h08
`define A_SNS 8'h0c
`define A_IDR 8'h10
`define A_IDS 8'h14
`define OP_READ_ID 3'h1
`define OP_RECAL 3'h2
`define OP_SEEK 3'h3
`define OP_SENSE 3'h4
`define CMD_OP 2:0
`define CMD_DRV 5:4
`define CFG_SRT 3:0
`define CFG_NOPOLL 4
`define CFG_NDMA 5
`define CFG_LOWPWR 6
`define CFG_RST 8'h00
`define TGT_RST 8'h00
`define IC_NORMAL 2'h0
`define IC_ABNORM 2'h1
`define IC_INVALID 2'h2
`define IC_POLL 2'h3
`define CLK_MHZ 100
`define STEP_UNIT_US 500
`define STEP_UNIT_CYC (`STEP_UNIT_US * `CLK_MHZ)
`define STEP_PULSE_NS 1000
`define STEP_PULSE_CYC ((`STEP_PULSE_NS * `CLK_MHZ) / 1000)
`define RECAL_MAX_STEPS 79
`define SRT_SPAN 5'h10
`endif

/* core/fdc_pos_pkg.sv */
// Types shared by the head positioning block
package fdc_pos_pkg;
  typedef enum logic [3:0] {
    P_IDLE   = 4'b0001,
    P_DECIDE = 4'b0010,
    P_PULSE  = 4'b0100,
    P_WAIT   = 4'b1000
  } pos_state_t;
  typedef enum logic [1:0] {
    ID_IDLE = 2'b01,
    ID_HUNT = 2'b10
  } id_state_t;
  typedef logic [1:0] term_class_t;
endpackage

/* core/drive_positioner.sv */
// Step sequencer and track counter for one drive
`timescale 1ns/100ps
`default_nettype none
`include "fdc_pos_map.svh"
module drive_positioner
  import fdc_pos_pkg::*;
#(
  parameter int TRACK_W   = 8,
  parameter int PULSE_CYC = `STEP_PULSE_CYC,
  parameter int RECAL_MAX = `RECAL_MAX_STEPS
) (
  input  wire logic               clk_sys,      // System clock
  input  wire logic               rstn,         // Async reset, low
  input  wire logic               unitTick,     // Step time unit
  input  wire logic [3:0]         stepInterval, // Step spacing code
  input  wire logic               startSeek,    // Begin seek
  input  wire logic               startRecal,   // Begin recalibrate
  input  wire logic [TRACK_W-1:0] targetIn,     // Seek target
  input  wire logic               trackZero,    // Filtered sense level
  input  wire logic               clearAll,     // Low power exit
  output logic                    stepOut,      // Step pulse pin
  output logic                    dirOut,       // 1 = step in
  output logic [TRACK_W-1:0]      presentTrack, // Track counter
  output logic                    doneEvt,      // Command end pulse
  output logic                    doneFault,    // End was a fault
  output logic                    active        // Sequence running
);
  pos_state_t         state_q;
  logic               isRecal_q;
  logic [6:0]         stepCnt_q;
  logic [7:0]         pulseCnt_q;
  logic [4:0]         gapCnt_q;
  logic [TRACK_W-1:0] tgt_q;
  logic               finish;

  assign active = (state_q != P_IDLE);
  assign finish = (state_q == P_DECIDE) && (isRecal_q ?
    (trackZero || stepCnt_q == 7'(RECAL_MAX)) : (presentTrack == tgt_q));

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= P_IDLE;
      isRecal_q <= 1'b0;
      stepCnt_q <= 7'h00;
      pulseCnt_q <= 8'h00;
      gapCnt_q <= 5'h00;
      tgt_q <= '0;
    end else if (clearAll) begin
      state_q <= P_IDLE;
    end else begin
      case (state_q)
        P_IDLE: begin
          if (startRecal || startSeek) begin
            state_q <= P_DECIDE;
            isRecal_q <= startRecal;
            stepCnt_q <= 7'h00;
            tgt_q <= targetIn;
          end
        end
        P_DECIDE: begin
          if (finish) begin
            state_q <= P_IDLE;
          end else begin
            state_q <= P_PULSE;
            pulseCnt_q <= 8'h00;
            stepCnt_q <= stepCnt_q + 7'h01;
          end
        end
        P_PULSE: begin
          if (pulseCnt_q == 8'(PULSE_CYC - 1)) begin
            state_q <= P_WAIT;
            gapCnt_q <= `SRT_SPAN - {1'b0, stepInterval};
          end else begin
            pulseCnt_q <= pulseCnt_q + 8'h01;
          end
        end
        P_WAIT: begin
          if (unitTick) begin
            if (gapCnt_q == 5'h01) begin
              state_q <= P_DECIDE;
            end else begin
              gapCnt_q <= gapCnt_q - 5'h01;
            end
          end
        end
        default: state_q <= P_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      presentTrack <= '0;
    end else if (clearAll || (state_q == P_IDLE && startRecal)) begin
      presentTrack <= '0;
    end else if (state_q == P_DECIDE && !finish && !isRecal_q) begin
      presentTrack <= (presentTrack < tgt_q) ? presentTrack + 1'b1 :
                      presentTrack - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stepOut <= 1'b0;
      dirOut <= 1'b0;
      doneEvt <= 1'b0;
      doneFault <= 1'b0;
    end else begin
      doneEvt <= finish && !clearAll;
      doneFault <= finish && isRecal_q && !trackZero;
      if (state_q == P_DECIDE && !finish && !clearAll) begin
        stepOut <= 1'b1;
        dirOut <= !isRecal_q && (presentTrack < tgt_q);
      end else if (state_q != P_PULSE || clearAll) begin
        stepOut <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  recal_dir_a: assert property (stepOut && isRecal_q |-> !dirOut)
    else $error("recalibrate stepped inward");
  recal_limit_a: assert property (doneEvt && doneFault |-> stepCnt_q == 7'(RECAL_MAX))
    else $error("track zero fault at wrong step count");
  seek_step_a: assert property ($rose(stepOut) && !isRecal_q |->
    presentTrack == (dirOut ? $past(presentTrack) + 1'b1 : $past(presentTrack) - 1'b1))
    else $error("seek step direction or count wrong");
  seek_end_a: assert property (doneEvt && !isRecal_q |-> presentTrack == tgt_q)
    else $error("seek ended off target");
  pulse_width_a: assert property ($fell(stepOut) && !$past(clearAll) |->
    $past(pulseCnt_q) == 8'(PULSE_CYC - 1))
    else $error("step pulse width wrong");
  cover_fault_c: cover property (doneEvt && doneFault);
endmodule
`default_nettype wire

/* core/floppy_head_positioning_control.sv */
// Head positioning control: registers, ID read, status sense, drives
`timescale 1ns/100ps
`default_nettype none
`include "fdc_pos_map.svh"
// How it works
// - Control commands move no data; three interrupt
// - ID read latches first ID field
// - Two index pulses, no ID: abnormal
// - Recalibrate clears track, steps outward
// - Track zero seen ends recalibrate normally
// - After 79 steps, fault and end
// - Positioning reports only via interrupt, sense
// - Positioning not busy; drives move together
// - Seek direction from track versus target
// - Steps paced; equal track ends seek
// - Head bit after seek reads zero
// - Low power exit clears tracks, status
// - Result phase entry raises interrupt
// - Positioning end raises interrupt
// - Non-DMA byte request raises interrupt
// - Sense clears interrupt, reports cause
// - Cause codes: poll, normal, abnormal
// - Unsensed drive stays busy
// - Interval sets step spacing, first shorter
// - Polling gives one interrupt after reset
module floppy_head_positioning_control
  import fdc_pos_pkg::*;
#(
  parameter int ND            = 4,
  parameter int TRACK_W       = 8,
  parameter int STEP_UNIT_CYC = `STEP_UNIT_CYC
) (
  input  wire logic          clk_sys,            // System clock
  input  wire logic          rstn,               // Async reset, low
  input  wire logic [7:0]    regAddr,            // Register address
  input  wire logic [31:0]   regWrData,          // Write data
  input  wire logic          regWr,              // Write strobe
  input  wire logic          regRd,              // Read strobe
  output logic      [31:0]   regRdData,          // Read data
  input  wire logic [ND-1:0] trackZeroSenseN,    // Track zero pins
  input  wire logic          indexPulseIn,       // Index pin
  input  wire logic          sectorHeaderMarker, // ID field found
  input  wire logic [7:0]    idCylinder,         // ID cylinder
  input  wire logic [7:0]    idHead,             // ID head
  input  wire logic [7:0]    idSector,           // ID sector
  input  wire logic [7:0]    idSize,             // ID size code
  input  wire logic          resultPhaseEntry,   // Other command result
  input  wire logic          dataXferReq,        // Byte wanted
  output logic      [ND-1:0] stepPulse,          // Step pins
  output logic      [ND-1:0] stepDir,            // Direction pins
  output logic               controllerIrq,      // Interrupt
  output logic               ctrlBusy            // Command busy
);
  localparam int UW = $clog2(STEP_UNIT_CYC + 1);
  function automatic logic [7:0] mkSt0(input term_class_t ic, input logic se,
                                       input logic ec, input logic [1:0] drv);
    mkSt0 = {ic, se, ec, 1'b0, 1'b0, drv};
  endfunction
  logic [ND:0]        sy1_q;
  logic [ND:0]        sy2_q;
  logic [ND:0]        sy3_q;
  logic [ND:0]        pinLvl_q;
  logic               idxPrev_q;
  logic               idxRise;
  logic [UW-1:0]      unitCnt_q;
  logic               unitTick_q;
  logic [7:0]         cfg_q;
  logic [TRACK_W-1:0] target_q;
  logic               lpPrev_q;
  logic               lpExit_q;
  logic               wrCmd;
  logic [2:0]         cmdOp;
  logic [1:0]         cmdDrv;
  logic               drvOk;
  logic               senseCmd;
  logic [ND-1:0]      startSeek;
  logic [ND-1:0]      startRecal;
  logic [ND-1:0]      posDone;
  logic [ND-1:0]      posFault;
  logic [ND-1:0]      posActive;
  logic [ND-1:0]      driveBusy;
  logic [TRACK_W-1:0] track [ND];
  logic [ND-1:0]      pend_q;
  logic [ND-1:0]      fault_q;
  logic               pollPend_q;
  logic               senseHit;
  logic [1:0]         senseDrv;
  logic [ND-1:0]      senseMask;
  logic [15:0]        sense_q;
  id_state_t          idState_q;
  logic [1:0]         idxCnt_q;
  logic [1:0]         idDrv_q;
  logic [31:0]        idRes_q;
  logic [31:0]        idField;
  logic [7:0]         idSt0_q;
  logic               noId_q;
  logic               idIrq_q;
  logic               resIrq_q;
  logic               idBusy;
  logic               idStart;
  logic               rdIds;

  // Pin inputs: three stages, change once stages two and three agree
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sy1_q <= '0;
      sy2_q <= '0;
      sy3_q <= '0;
      pinLvl_q <= '0;
      idxPrev_q <= 1'b0;
    end else begin
      sy1_q <= {indexPulseIn, trackZeroSenseN};
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
      pinLvl_q <= (~(sy2_q ^ sy3_q) & sy3_q) | ((sy2_q ^ sy3_q) & pinLvl_q);
      idxPrev_q <= pinLvl_q[ND];
    end
  end
  assign idxRise = pinLvl_q[ND] && !idxPrev_q;
  // Step time unit divider
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      unitCnt_q <= '0;
      unitTick_q <= 1'b0;
    end else begin
      unitTick_q <= (unitCnt_q == UW'(STEP_UNIT_CYC - 1));
      if (unitCnt_q == UW'(STEP_UNIT_CYC - 1)) begin
        unitCnt_q <= '0;
      end else begin
        unitCnt_q <= unitCnt_q + 1'b1;
      end
    end
  end

  // Command decode
  assign wrCmd = regWr && (regAddr == `A_CMD);
  assign cmdOp = regWrData[`CMD_OP];
  assign cmdDrv = regWrData[`CMD_DRV];
  assign drvOk = (int'(cmdDrv) < ND);
  assign senseCmd = wrCmd && (cmdOp == `OP_SENSE);
  assign idStart = wrCmd && (cmdOp == `OP_READ_ID) && !idBusy && drvOk;
  assign idBusy = (idState_q == ID_HUNT);
  assign rdIds = regRd && (regAddr == `A_IDS);
  assign driveBusy = posActive | pend_q;
  always_comb begin
    startSeek = '0;
    startRecal = '0;
    if (wrCmd && drvOk && !cfg_q[`CFG_LOWPWR] && !driveBusy[cmdDrv]) begin
      startSeek[cmdDrv] = (cmdOp == `OP_SEEK);
      startRecal[cmdDrv] = (cmdOp == `OP_RECAL);
    end
  end

  // Software settings
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= `CFG_RST;
      target_q <= TRACK_W'(`TGT_RST);
    end else if (regWr) begin
      if (regAddr == `A_CFG) begin
        cfg_q <= {1'b0, regWrData[6:0]};
      end
      if (regAddr == `A_TGT) begin
        target_q <= regWrData[TRACK_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lpPrev_q <= 1'b0;
      lpExit_q <= 1'b0;
    end else begin
      lpPrev_q <= cfg_q[`CFG_LOWPWR];
      lpExit_q <= lpPrev_q && !cfg_q[`CFG_LOWPWR];
    end
  end

  for (genvar g = 0; g < ND; g++) begin : g_drv
    drive_positioner #(
      .TRACK_W (TRACK_W)
    ) u_pos (
      .clk_sys      (clk_sys),
      .rstn         (rstn),
      .unitTick     (unitTick_q),
      .stepInterval (cfg_q[`CFG_SRT]),
      .startSeek    (startSeek[g]),
      .startRecal   (startRecal[g]),
      .targetIn     (target_q),
      .trackZero    (pinLvl_q[g]),
      .clearAll     (lpExit_q),
      .stepOut      (stepPulse[g]),
      .dirOut       (stepDir[g]),
      .presentTrack (track[g]),
      .doneEvt      (posDone[g]),
      .doneFault    (posFault[g]),
      .active       (posActive[g])
    );
  end

  always_comb begin
    senseHit = 1'b0;
    senseDrv = 2'h0;
    for (int i = ND - 1; i >= 0; i--) begin
      if (pend_q[i]) begin
        senseHit = 1'b1;
        senseDrv = 2'(i);
      end
    end
    senseMask = '0;
    if (senseCmd && !pollPend_q && senseHit) begin
      senseMask[senseDrv] = 1'b1;
    end
  end

  // pending end per drive, set wins
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pend_q <= '0;
      fault_q <= '0;
    end else if (lpExit_q) begin
      pend_q <= '0;
      fault_q <= '0;
    end else begin
      pend_q <= posDone | (pend_q & ~senseMask);
      fault_q <= (posDone & posFault) | (fault_q & ~posDone);
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pollPend_q <= 1'b1;
    end else if (lpExit_q || senseCmd || cfg_q[`CFG_NOPOLL]) begin
      pollPend_q <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sense_q <= 16'h0000;
    end else if (lpExit_q) begin
      sense_q <= 16'h0000;
    end else if (senseCmd) begin
      if (pollPend_q) begin
        sense_q <= {8'h00, mkSt0(`IC_POLL, 1'b0, 1'b0, 2'h0)};
      end else if (senseHit) begin
        sense_q <= {8'(track[senseDrv]), mkSt0(fault_q[senseDrv] ?
                    `IC_ABNORM : `IC_NORMAL, 1'b1, fault_q[senseDrv], senseDrv)};
      end else begin
        sense_q <= {8'h00, mkSt0(`IC_INVALID, 1'b0, 1'b0, 2'h0)};
      end
    end
  end

  assign idField = {idSize, idSector, idHead, idCylinder};
  // ID read hunts up to two index pulses
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      idState_q <= ID_IDLE;
      idxCnt_q <= 2'h0;
      idDrv_q <= 2'h0;
      idRes_q <= 32'h0;
      idSt0_q <= 8'h00;
      noId_q <= 1'b0;
    end else if (lpExit_q) begin
      idState_q <= ID_IDLE;
      idSt0_q <= 8'h00;
      noId_q <= 1'b0;
    end else begin
      case (idState_q)
        ID_IDLE: begin
          if (idStart) begin
            idState_q <= ID_HUNT;
            idxCnt_q <= 2'h0;
            idDrv_q <= cmdDrv;
          end
        end
        ID_HUNT: begin
          if (sectorHeaderMarker) begin
            idRes_q <= idField;
            idSt0_q <= mkSt0(`IC_NORMAL, 1'b0, 1'b0, idDrv_q);
            noId_q <= 1'b0;
            idState_q <= ID_IDLE;
          end else if (idxRise && idxCnt_q == 2'h1) begin
            idSt0_q <= mkSt0(`IC_ABNORM, 1'b0, 1'b0, idDrv_q);
            noId_q <= 1'b1;
            idState_q <= ID_IDLE;
          end else if (idxRise) begin
            idxCnt_q <= idxCnt_q + 2'h1;
          end
        end
        default: idState_q <= ID_IDLE;
      endcase
    end
  end
  // result interrupts, set wins over clear
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      idIrq_q <= 1'b0;
      resIrq_q <= 1'b0;
    end else begin
      idIrq_q <= (idBusy && (sectorHeaderMarker || (idxRise && idxCnt_q == 2'h1)))
                 || (idIrq_q && !senseCmd && !rdIds && !lpExit_q);
      resIrq_q <= resultPhaseEntry || (resIrq_q && !senseCmd && !lpExit_q);
    end
  end
  assign controllerIrq = (|pend_q) || pollPend_q || idIrq_q || resIrq_q ||
                         (dataXferReq && cfg_q[`CFG_NDMA]);
  // busy only while ID read runs
  assign ctrlBusy = idBusy;
  // Register reads, data one cycle after strobe
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      regRdData <= 32'h0;
    end else if (regRd) begin
      case (regAddr)
        `A_CMD: regRdData <= {24'h0, idBusy, 3'h0, 4'(driveBusy)};
        `A_TGT: regRdData <= 32'(target_q);
        `A_CFG: regRdData <= {24'h0, cfg_q};
        `A_SNS: regRdData <= {16'h0, sense_q};
        `A_IDR: regRdData <= idRes_q;
        `A_IDS: regRdData <= {23'h0, noId_q, idSt0_q};
        default: regRdData <= 32'h0;
      endcase
    end else begin
      regRdData <= 32'h0;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  id_timeout_a: assert property (idBusy && idxRise && idxCnt_q == 2'h1 && !sectorHeaderMarker
    |=> noId_q && idSt0_q[7:6] == `IC_ABNORM && controllerIrq)
    else $error("missing ID not flagged");
  id_latch_a: assert property (idBusy && sectorHeaderMarker |=> idRes_q == $past(idField)
    && !noId_q)
    else $error("ID field not latched");
  sense_clear_a: assert property (senseCmd && !pollPend_q && !(|posDone) && !lpExit_q
    |=> pend_q == ($past(pend_q) & ~$past(senseMask)))
    else $error("sense did not clear pending drive");
  sense_head_a: assert property (senseCmd |=> !sense_q[2] && !idSt0_q[2])
    else $error("head bit set in result");
  poll_code_a: assert property (senseCmd && pollPend_q
    |=> sense_q[7:5] == {`IC_POLL, 1'b0} && !pollPend_q)
    else $error("poll cause wrong");
  irq_end_a: assert property ((|posDone) && !lpExit_q |=> controllerIrq [*2])
    else $error("positioning end gave no interrupt");
  seek_nobusy_a: assert property (|(startSeek | startRecal) && !idBusy |=> !ctrlBusy
    && (posActive & $past(startSeek | startRecal)) == $past(startSeek | startRecal))
    else $error("busy during positioning");
  lp_clear_a: assert property (lpExit_q |=> pend_q == '0 && !pollPend_q
    && sense_q == 16'h0000)
    else $error("low power exit left status");
  result_irq_a: assert property (resultPhaseEntry |=> controllerIrq)
    else $error("result phase gave no interrupt");
  cover_seek_c: cover property (|(startSeek) ##[1:1000] (|posDone));
  cover_idto_c: cover property (idBusy && idxRise && idxCnt_q == 2'h1);
  cover_sense_c: cover property (senseCmd && senseHit && !pollPend_q);
endmodule
`default_nettype wire

/* dv/floppy_drive_model.sv */
// Drive model: head position per drive, step counting, track zero sense
`timescale 1ns/100ps
`default_nettype none
module floppy_drive_model #(
  parameter int ND = 4
) (
  input  wire logic          clk_sys,         // System clock
  input  wire logic [ND-1:0] stepPulse,       // Step pins
  input  wire logic [ND-1:0] stepDir,         // Direction pins
  output logic      [ND-1:0] trackZeroSenseN  // High at track zero
);
  int headPos [ND];
  int pulses  [ND];
  logic [ND-1:0] stepPrev = '0;

  // Head moves one track per step rise, stops at track zero
  always @(posedge clk_sys) begin
    stepPrev <= stepPulse;
    for (int i = 0; i < ND; i++) begin
      if (stepPulse[i] && !stepPrev[i]) begin
        pulses[i]++;
        if (stepDir[i]) begin
          headPos[i] = headPos[i] + 1;
        end else if (headPos[i] > 0) begin
          headPos[i] = headPos[i] - 1;
        end
      end
    end
  end

  always @* begin
    for (int i = 0; i < ND; i++) begin
      trackZeroSenseN[i] = (headPos[i] == 0);
    end
  end
endmodule
`default_nettype wire

/* dv/test_floppy_head_positioning_control.sv */
// Self-checking bench for the head positioning control block
`timescale 1ns/100ps
`default_nettype none
`include "fdc_pos_map.svh"
module test_floppy_head_positioning_control
  import fdc_pos_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [31:0] regRdData;
  logic [3:0]  trackZeroSenseN;
  logic        indexPulseIn = 1'b0;
  logic        sectorHeaderMarker = 1'b0;
  logic [7:0]  idCylinder = 8'h00;
  logic [7:0]  idHead = 8'h00;
  logic [7:0]  idSector = 8'h00;
  logic [7:0]  idSize = 8'h00;
  logic        resultPhaseEntry = 1'b0;
  logic        dataXferReq = 1'b0;
  logic [3:0]  stepPulse;
  logic [3:0]  stepDir;
  logic        controllerIrq;
  logic        ctrlBusy;
  int          n_errors = 0;
  int          check_count = 0;
  logic [31:0] rdv;

  floppy_head_positioning_control #(.ND(4), .TRACK_W(8), .STEP_UNIT_CYC(8))
    floppy_head_positioning_control_inst (.clk_sys(clk_sys), .rstn(rstn),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .trackZeroSenseN(trackZeroSenseN),
    .indexPulseIn(indexPulseIn), .sectorHeaderMarker(sectorHeaderMarker),
    .idCylinder(idCylinder), .idHead(idHead), .idSector(idSector), .idSize(idSize),
    .resultPhaseEntry(resultPhaseEntry), .dataXferReq(dataXferReq),
    .stepPulse(stepPulse), .stepDir(stepDir), .controllerIrq(controllerIrq),
    .ctrlBusy(ctrlBusy));

  floppy_drive_model #(.ND(4)) floppy_drive_model_inst (.clk_sys(clk_sys),
    .stepPulse(stepPulse), .stepDir(stepDir), .trackZeroSenseN(trackZeroSenseN));

  initial forever #5 clk_sys = ~clk_sys;

  task automatic summarize;
    $display("Checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask

  task automatic cmd(input logic [1:0] drv, input logic [2:0] op);
    wr(`A_CMD, {26'h0, drv, 1'b0, op});
  endtask

  task automatic sns(input logic [1:0] drv, input logic [15:0] e);
    cmd(drv, `OP_SENSE);
    rd(`A_SNS, rdv);
    chk("sense", {16'h0, e}, {16'h0, rdv[15:0]});
  endtask

  // Bounded wait for the interrupt
  task automatic wirq;
    int i;
    for (i = 0; i < 20000 && controllerIrq !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    if (i == 20000) begin
      chk("irqWait", 1, 0);
      summarize;
    end
  endtask

  // Start a move, check first step and its direction, wait for the end
  task automatic move(input logic [1:0] drv, input logic [2:0] op, input logic [7:0] t,
                      input logic d);
    int i;
    wr(`A_TGT, {24'h0, t});
    cmd(drv, op);
    for (i = 0; i < 2000 && stepPulse[drv] !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    if (i == 2000) begin
      chk("stepWait", 1, 0);
      summarize;
    end
    chk("step", {30'h0, 1'b1, d}, {30'h0, stepPulse[drv], stepDir[drv]});
    wirq;
  endtask

  initial begin
    int i;
    floppy_drive_model_inst.headPos = '{3, 0, 0, 100};
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk("pollIrq", 1, controllerIrq);
    wr(`A_CFG, 32'h0f);
    sns(0, 16'h00c0);
    chk("irqClear", 0, controllerIrq);
    move(0, `OP_RECAL, 8'h00, 1'b0);
    sns(0, 16'h0020);
    move(0, `OP_SEEK, 8'h05, 1'b1);
    rd(`A_CMD, rdv);
    chk("driveBusy", 1, rdv[0]);
    wr(`A_TGT, 32'h06);
    cmd(0, `OP_SEEK);
    sns(0, 16'h0520);
    chk("headPos", 5, floppy_drive_model_inst.headPos[0]);
    move(0, `OP_SEEK, 8'h02, 1'b0);
    sns(0, 16'h0220);
    // Three drives moving together
    wr(`A_TGT, 32'h03);
    cmd(1, `OP_SEEK);
    wr(`A_TGT, 32'h01);
    cmd(2, `OP_SEEK);
    cmd(3, `OP_RECAL);
    #1;
    chk("notBusy", 0, ctrlBusy);
    for (i = 0; i < 20000 && floppy_drive_model_inst.pulses[3] < 79; i++) begin
      @(posedge clk_sys);
    end
    if (i == 20000) begin
      chk("stepCountWait", 1, 0);
      summarize;
    end
    repeat (300) @(posedge clk_sys);
    chk("faultSteps", 79, floppy_drive_model_inst.pulses[3]);
    sns(1, 16'h0321);
    sns(2, 16'h0122);
    cmd(3, `OP_SENSE);
    rd(`A_SNS, rdv);
    chk("faultSt0", 32'h73, {24'h0, rdv[7:0]});
    // Identification field found
    cmd(0, `OP_READ_ID);
    #1;
    chk("idBusy", 1, ctrlBusy);
    @(posedge clk_sys);
    sectorHeaderMarker <= 1'b1;
    idCylinder         <= 8'h2a;
    idHead             <= 8'h01;
    idSector           <= 8'h07;
    idSize             <= 8'h02;
    @(posedge clk_sys);
    sectorHeaderMarker <= 1'b0;
    wirq;
    rd(`A_IDR, rdv);
    chk("idFields", 32'h0207012a, rdv);
    rd(`A_IDS, rdv);
    chk("idStatus", 0, rdv[8:6]);
    chk("idIrq", 0, controllerIrq);
    // No field before the second index
    cmd(0, `OP_READ_ID);
    repeat (2) begin
      @(posedge clk_sys);
      indexPulseIn <= 1'b1;
      repeat (10) @(posedge clk_sys);
      indexPulseIn <= 1'b0;
      repeat (20) @(posedge clk_sys);
    end
    wirq;
    rd(`A_IDS, rdv);
    chk("noId", 32'h5, {29'h0, rdv[8:6]});
    @(posedge clk_sys);
    resultPhaseEntry <= 1'b1;
    @(posedge clk_sys);
    resultPhaseEntry <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("resultIrq", 1, controllerIrq);
    cmd(0, `OP_SENSE);
    @(posedge clk_sys);
    #1;
    chk("resultClr", 0, controllerIrq);
    @(posedge clk_sys);
    dataXferReq <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk("dmaNoIrq", 0, controllerIrq);
    wr(`A_CFG, 32'h2f);
    #1;
    chk("byteIrq", 1, controllerIrq);
    @(posedge clk_sys);
    dataXferReq <= 1'b0;
    #1;
    chk("irqBeforeLp", 0, controllerIrq);
    wr(`A_CFG, 32'h4f);
    wr(`A_CFG, 32'h0f);
    repeat (4) @(posedge clk_sys);
    rd(`A_SNS, rdv);
    chk("lowPwrSense", 0, rdv);
    cmd(0, `OP_SENSE);
    rd(`A_SNS, rdv);
    chk("lowPwrTrack", 32'h2, {22'h0, rdv[15:6]});
    rd(8'h1c, rdv);
    chk("unmapped", 0, rdv);
    summarize;
  end
endmodule
`default_nettype wire
